// *** src/tfs_timer.sv ***
// timer flag and status logic of a 16-bit free-running timer
// assumes one 250 MHz clock, synchronous inputs and a simple register
// port: address, write data, write strobe, read strobe, data next cycle
//
// What this block does
// RULE1 - capture one on pin edge or pwm compare two
// RULE2 - capture one clears: status read, capture one low
// RULE3 - compare one flag on counter equal value one
// RULE4 - compare one clears: status read, compare one low
// RULE5 - rollover flag when counter wraps to zero
// RULE6 - rollover clears: status read, main counter low
// RULE7 - alternate counter low never clears rollover
// RULE8 - capture two flag on capture pin two edge
// RULE9 - capture two clears: status read, capture two low
// RULE10 - compare two flag on counter equal value two
// RULE11 - compare two clears: status read, compare two low
// RULE12 - freeze stops prescaler, counter, compare outputs
// RULE13 - freeze bit written and read by software
// RULE14 - registers stay accessible while frozen
// RULE15 - software writes status low bits as zero
// RULE16 - status register resets to all zeros
// RULE17 - flags sticky; new event beats clear
`timescale 1ns/10ps
`default_nettype none
`include "tfs_cfg.svh"

module tfs_timer #(
    parameter logic [`TFS_PRE_W-1:0] PRESCALE_RESET = `TFS_PRE_DEFAULT
) (
    input  wire logic                   clk_in,        // 250 MHz clock
    input  wire logic                   rst_b_in,      // async reset, low
    input  wire logic [`TFS_ADDR_W-1:0] addr_in,       // register address
    input  wire logic [`TFS_DATA_W-1:0] wdata_in,      // write data
    input  wire logic                   wr_in,         // write strobe
    input  wire logic                   rd_in,         // read strobe
    input  wire logic                   capture_pin_one_in, // capture one
    input  wire logic                   capture_pin_two_in, // capture two
    output logic [`TFS_DATA_W-1:0]      rdata_out,     // read data
    output logic                        compare_output_pin_one_out,
    output logic                        compare_output_pin_two_out,
    output logic                        irq_out        // level interrupt
);
    import tfs_pkg::*;

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------

    // one strobe at a given offset
    function automatic logic hit(input logic [`TFS_ADDR_W-1:0] a,
                                 input logic [`TFS_ADDR_W-1:0] ofs,
                                 input logic                   stb);
        hit = stb && (a == ofs);
    endfunction : hit

    // pick the high or low byte of a 16-bit value
    function automatic logic [`TFS_DATA_W-1:0] byte_of(
        input logic [`TFS_CNT_W-1:0] v,
        input logic                  hi);
        byte_of = hi ? v[`TFS_CNT_W-1:`TFS_DATA_W] : v[`TFS_DATA_W-1:0];
    endfunction : byte_of

    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    logic       rst_meta_reg;   // first synchroniser stage
    logic       rst_sync_reg;   // released reset, active high = running

    // two flops so the release is clean against clk_in
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    tfs_state_t st_reg;         // registered state
    tfs_state_t st_next;        // next state

    logic       any_access;     // read or write this cycle
    logic       tick;           // prescaler enable pulse
    logic [`TFS_CNT_W-1:0] cnt_inc;  // counter after a tick
    logic [`TFS_EVT_W-1:0] evt;      // events raised this cycle
    logic [`TFS_EVT_W-1:0] clr_acc;  // clearing low-byte accesses
    logic [`TFS_EVT_W-1:0] clr;      // flags cleared this cycle
    logic       cap1_edge;      // rising edge on capture pin one
    logic       cap2_edge;      // rising edge on capture pin two
    logic       cmp1_hit;       // counter lands on compare one
    logic       cmp2_hit;       // counter lands on compare two
    logic [`TFS_DATA_W-1:0] status_byte; // status register view

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        st_next    = st_reg;
        any_access = rd_in || wr_in;

        // status view: flags, freeze, low two bits always zero
        status_byte = `TFS_RST_BYTE;
        status_byte[`TFS_BIT_CAP1]   = st_reg.flags[`TFS_EV_CAP1];
        status_byte[`TFS_BIT_CMP1]   = st_reg.flags[`TFS_EV_CMP1];
        status_byte[`TFS_BIT_ROLL]   = st_reg.flags[`TFS_EV_ROLL];
        status_byte[`TFS_BIT_CAP2]   = st_reg.flags[`TFS_EV_CAP2];
        status_byte[`TFS_BIT_CMP2]   = st_reg.flags[`TFS_EV_CMP2];
        // RULE13 freeze read back
        status_byte[`TFS_BIT_FREEZE] = st_reg.freeze;

        // RULE12 prescaler held while frozen
        tick = 1'b0;
        if (!st_reg.freeze) begin
            if (st_reg.pre_cnt == `TFS_RST_PRE) begin
                tick = 1'b1;
                st_next.pre_cnt = st_reg.pre_div;
            end else begin
                st_next.pre_cnt = st_reg.pre_cnt - 1'b1;
            end
        end

        // RULE12 counter held while frozen
        cnt_inc = st_reg.cnt + 1'b1;
        if (tick) begin
            st_next.cnt = cnt_inc;
        end

        // compare matches are judged on the value just reached, so a
        // frozen counter that sits on a compare value raises nothing
        // RULE3 compare one match
        cmp1_hit = tick && (cnt_inc == st_reg.cmp1);
        // RULE10 compare two match
        cmp2_hit = tick && (cnt_inc == st_reg.cmp2);

        // capture pins sampled as synchronous; rising edge captures
        cap1_edge = capture_pin_one_in && !st_reg.cap1_prev;
        cap2_edge = capture_pin_two_in && !st_reg.cap2_prev;
        st_next.cap1_prev = capture_pin_one_in;
        st_next.cap2_prev = capture_pin_two_in;

        // event vector
        evt = `TFS_RST_EVT;
        // RULE1 pin edge, or compare two reached in pwm mode
        evt[`TFS_EV_CAP1] = st_reg.pwm ? cmp2_hit : cap1_edge;
        evt[`TFS_EV_CMP1] = cmp1_hit;
        // RULE5 wrap from the maximum to zero
        evt[`TFS_EV_ROLL] = tick && (st_reg.cnt == `TFS_CNT_MAX);
        // RULE8 capture two on pin edge
        evt[`TFS_EV_CAP2] = cap2_edge;
        evt[`TFS_EV_CMP2] = cmp2_hit;

        // capture registers follow their events
        if (evt[`TFS_EV_CAP1]) begin
            st_next.cap1 = st_reg.pwm ? cnt_inc : st_reg.cnt;
        end
        if (cap2_edge) begin
            st_next.cap2 = st_reg.cnt;
        end

        // compare outputs: toggle per match, or pwm waveform where
        // compare one raises and compare two drops output one
        if (st_reg.pwm) begin
            if (cmp1_hit) begin
                st_next.out1 = 1'b1;
            end else if (cmp2_hit) begin
                st_next.out1 = 1'b0;
            end
        end else if (cmp1_hit) begin
            st_next.out1 = !st_reg.out1;
        end
        if (cmp2_hit && !st_reg.pwm) begin
            st_next.out2 = !st_reg.out2;
        end

        // accesses of the low bytes that finish a clear sequence
        clr_acc = `TFS_RST_EVT;
        // RULE2 capture one low byte
        clr_acc[`TFS_EV_CAP1] = hit(addr_in, `TFS_OFS_CAP1_LO, any_access);
        // RULE4 compare one low byte
        clr_acc[`TFS_EV_CMP1] = hit(addr_in, `TFS_OFS_CMP1_LO, any_access);
        // RULE6 main counter low only
        // RULE7 alternate low byte is not decoded here
        clr_acc[`TFS_EV_ROLL] = hit(addr_in, `TFS_OFS_CNT_LO, any_access);
        // RULE9 capture two low byte
        clr_acc[`TFS_EV_CAP2] = hit(addr_in, `TFS_OFS_CAP2_LO, any_access);
        // RULE11 compare two low byte
        clr_acc[`TFS_EV_CMP2] = hit(addr_in, `TFS_OFS_CMP2_LO, any_access);

        // a flag clears only if it was already set when the status
        // register was read; a flag raised later needs a fresh read
        clr = clr_acc & st_reg.armed & st_reg.flags;

        // RULE17 set beats clear
        st_next.flags = (st_reg.flags & ~clr) | evt;
        st_next.armed = st_reg.armed & ~clr;
        if (hit(addr_in, `TFS_OFS_STATUS, rd_in)) begin
            st_next.armed = st_reg.flags;
        end

        // interrupt status is a second, write-one-to-clear copy of
        // the events; a new event beats the clear here as well
        st_next.irq_st = st_reg.irq_st | evt;
        if (hit(addr_in, `TFS_OFS_IRQ_ST, wr_in)) begin
            st_next.irq_st = (st_reg.irq_st & ~wdata_in[`TFS_EVT_W-1:0])
                           | evt;
        end

        // RULE14 writes are taken whether frozen or not
        if (wr_in) begin
            unique case (addr_in)
                `TFS_OFS_STATUS: begin
                    // RULE13 only the freeze bit is writable
                    // RULE15 low bits ignored, read back as zero
                    st_next.freeze = wdata_in[`TFS_BIT_FREEZE];
                end
                `TFS_OFS_CTRL: begin
                    st_next.pwm = wdata_in[`TFS_BIT_PWM];
                end
                `TFS_OFS_CMP1_HI: begin
                    st_next.cmp1[`TFS_CNT_W-1:`TFS_DATA_W] = wdata_in;
                end
                `TFS_OFS_CMP1_LO: begin
                    st_next.cmp1[`TFS_DATA_W-1:0] = wdata_in;
                end
                `TFS_OFS_CMP2_HI: begin
                    st_next.cmp2[`TFS_CNT_W-1:`TFS_DATA_W] = wdata_in;
                end
                `TFS_OFS_CMP2_LO: begin
                    st_next.cmp2[`TFS_DATA_W-1:0] = wdata_in;
                end
                `TFS_OFS_IRQ_MSK: begin
                    st_next.irq_msk = wdata_in[`TFS_EVT_W-1:0];
                end
                `TFS_OFS_PRESCL: begin
                    st_next.pre_div = wdata_in;
                end
                default: begin
                    // counters and captures are read-only; the
                    // interrupt status clear is handled above
                end
            endcase
        end

        // read data, registered; unmapped offsets read as zero
        st_next.rdata = `TFS_RST_BYTE;
        if (rd_in) begin
            unique case (addr_in)
                `TFS_OFS_STATUS:  st_next.rdata = status_byte;
                `TFS_OFS_CTRL: begin
                    st_next.rdata[`TFS_BIT_PWM] = st_reg.pwm;
                end
                `TFS_OFS_CNT_HI:  st_next.rdata = byte_of(st_reg.cnt, 1'b1);
                `TFS_OFS_CNT_LO:  st_next.rdata = byte_of(st_reg.cnt, 1'b0);
                `TFS_OFS_ALT_HI:  st_next.rdata = byte_of(st_reg.cnt, 1'b1);
                `TFS_OFS_ALT_LO:  st_next.rdata = byte_of(st_reg.cnt, 1'b0);
                `TFS_OFS_CAP1_HI: st_next.rdata = byte_of(st_reg.cap1, 1'b1);
                `TFS_OFS_CAP1_LO: st_next.rdata = byte_of(st_reg.cap1, 1'b0);
                `TFS_OFS_CAP2_HI: st_next.rdata = byte_of(st_reg.cap2, 1'b1);
                `TFS_OFS_CAP2_LO: st_next.rdata = byte_of(st_reg.cap2, 1'b0);
                `TFS_OFS_CMP1_HI: st_next.rdata = byte_of(st_reg.cmp1, 1'b1);
                `TFS_OFS_CMP1_LO: st_next.rdata = byte_of(st_reg.cmp1, 1'b0);
                `TFS_OFS_CMP2_HI: st_next.rdata = byte_of(st_reg.cmp2, 1'b1);
                `TFS_OFS_CMP2_LO: st_next.rdata = byte_of(st_reg.cmp2, 1'b0);
                `TFS_OFS_IRQ_ST: begin
                    st_next.rdata[`TFS_EVT_W-1:0] = st_reg.irq_st;
                end
                `TFS_OFS_IRQ_MSK: begin
                    st_next.rdata[`TFS_EVT_W-1:0] = st_reg.irq_msk;
                end
                `TFS_OFS_PRESCL:  st_next.rdata = st_reg.pre_div;
                default:          st_next.rdata = `TFS_RST_BYTE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------

    // RULE16 flags and status clear on reset, compare values load ffff, prescaler reload loads PRESCALE_RESET; timer running
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_reg.cnt       <= `TFS_RST_CNT;
            st_reg.pre_cnt   <= `TFS_RST_PRE;
            st_reg.pre_div   <= PRESCALE_RESET;
            st_reg.cap1      <= `TFS_RST_CNT;
            st_reg.cap2      <= `TFS_RST_CNT;
            st_reg.cmp1      <= `TFS_CNT_MAX;
            st_reg.cmp2      <= `TFS_CNT_MAX;
            st_reg.flags     <= `TFS_RST_EVT;
            st_reg.armed     <= `TFS_RST_EVT;
            st_reg.freeze    <= 1'b0;
            st_reg.pwm       <= 1'b0;
            st_reg.irq_st    <= `TFS_RST_EVT;
            st_reg.irq_msk   <= `TFS_RST_EVT;
            st_reg.cap1_prev <= 1'b0;
            st_reg.cap2_prev <= 1'b0;
            st_reg.out1      <= 1'b0;
            st_reg.out2      <= 1'b0;
            st_reg.rdata     <= `TFS_RST_BYTE;
        end else if (!rst_sync_reg) begin
            // hold reset values until the release has been synchronised
            st_reg <= st_reg;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign rdata_out = st_reg.rdata;
    // RULE12 compare outputs gated off while frozen
    assign compare_output_pin_one_out = st_reg.out1 && !st_reg.freeze;
    assign compare_output_pin_two_out = st_reg.out2 && !st_reg.freeze;
    // level interrupt while any unmasked sticky bit stands
    assign irq_out = |(st_reg.irq_st & st_reg.irq_msk);

endmodule : tfs_timer
`default_nettype wire

// *** common/tfs_cfg.svh ***
// constants of the timer flag and status block: offsets, fields, resets
// assumes an 8-bit register port with a 5-bit byte address
`ifndef TFS_CFG_SVH
`define TFS_CFG_SVH

// ----------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------
`define TFS_CNT_W        16
`define TFS_DATA_W       8
`define TFS_ADDR_W       5
`define TFS_EVT_W        5
`define TFS_PRE_W        8

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define TFS_OFS_STATUS   5'h00
`define TFS_OFS_CTRL     5'h01
`define TFS_OFS_CNT_HI   5'h02
`define TFS_OFS_CNT_LO   5'h03
`define TFS_OFS_ALT_HI   5'h04
`define TFS_OFS_ALT_LO   5'h05
`define TFS_OFS_CAP1_HI  5'h06
`define TFS_OFS_CAP1_LO  5'h07
`define TFS_OFS_CAP2_HI  5'h08
`define TFS_OFS_CAP2_LO  5'h09
`define TFS_OFS_CMP1_HI  5'h0a
`define TFS_OFS_CMP1_LO  5'h0b
`define TFS_OFS_CMP2_HI  5'h0c
`define TFS_OFS_CMP2_LO  5'h0d
`define TFS_OFS_IRQ_ST   5'h0e
`define TFS_OFS_IRQ_MSK  5'h0f
`define TFS_OFS_PRESCL   5'h10

// ----------------------------------------------------------------------
// status fields (bit positions) and control fields
// ----------------------------------------------------------------------
`define TFS_BIT_CAP1     7
`define TFS_BIT_CMP1     6
`define TFS_BIT_ROLL     5
`define TFS_BIT_CAP2     4
`define TFS_BIT_CMP2     3
`define TFS_BIT_FREEZE   2
`define TFS_BIT_PWM      0
// event index inside the 5-bit event vectors
`define TFS_EV_CAP1      4
`define TFS_EV_CMP1      3
`define TFS_EV_ROLL      2
`define TFS_EV_CAP2      1
`define TFS_EV_CMP2      0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define TFS_RST_BYTE     8'h00
`define TFS_RST_CNT      16'h0000
`define TFS_RST_EVT      5'h00
`define TFS_CNT_MAX      16'hffff
`define TFS_RST_PRE      8'h00
`define TFS_PRE_DEFAULT  8'h03

`endif

// *** common/tfs_pkg.sv ***
// types of the timer flag and status block
// assumes tfs_cfg.svh is on the include path
`include "tfs_cfg.svh"

package tfs_pkg;

    // state of the block except the reset synchroniser, registered as one word
    typedef struct packed {
        logic [`TFS_CNT_W-1:0]  cnt;       // free-running counter
        logic [`TFS_PRE_W-1:0]  pre_cnt;   // prescaler divider
        logic [`TFS_PRE_W-1:0]  pre_div;   // prescaler reload
        logic [`TFS_CNT_W-1:0]  cap1;      // capture value one
        logic [`TFS_CNT_W-1:0]  cap2;      // capture value two
        logic [`TFS_CNT_W-1:0]  cmp1;      // compare value one
        logic [`TFS_CNT_W-1:0]  cmp2;      // compare value two
        logic [`TFS_EVT_W-1:0]  flags;     // status flags
        logic [`TFS_EVT_W-1:0]  armed;     // seen by a status read
        logic                   freeze;    // timer freeze
        logic                   pwm;       // pwm mode
        logic [`TFS_EVT_W-1:0]  irq_st;    // sticky interrupt status
        logic [`TFS_EVT_W-1:0]  irq_msk;   // interrupt mask
        logic                   cap1_prev; // last capture pin one level
        logic                   cap2_prev; // last capture pin two level
        logic                   out1;      // compare output one level
        logic                   out2;      // compare output two level
        logic [`TFS_DATA_W-1:0] rdata;     // read data
    } tfs_state_t;

endpackage : tfs_pkg

// *** tb/tfs_timer_monitor.sv ***
// checker of the timer flag and status block, sees the top ports only
// assumes tfs_cfg.svh on the include path; bound at the foot of this file
`timescale 1ns/10ps
`default_nettype none
`include "tfs_cfg.svh"

module tfs_timer_monitor #(
    parameter logic [`TFS_PRE_W-1:0] PRESCALE_RESET = `TFS_PRE_DEFAULT
) (
    input wire logic                   clk_in,
    input wire logic                   rst_b_in,
    input wire logic [`TFS_ADDR_W-1:0] addr_in,
    input wire logic [`TFS_DATA_W-1:0] wdata_in,
    input wire logic                   wr_in,
    input wire logic                   rd_in,
    input wire logic                   capture_pin_one_in,
    input wire logic                   capture_pin_two_in,
    input wire logic [`TFS_DATA_W-1:0] rdata_out,
    input wire logic                   compare_output_pin_one_out,
    input wire logic                   compare_output_pin_two_out,
    input wire logic                   irq_out
);
    import tfs_pkg::*;
    // ------------------------------------------------------------------
    // helper state: what software last wrote, capture two bookkeeping
    // ------------------------------------------------------------------
    logic       frz_reg;     // freeze bit as last written
    logic [4:0] msk_reg;     // interrupt mask as last written
    logic       c2_prev_reg; // capture two pin, previous sample
    logic       c2_pend_reg; // capture two edge not yet cleared
    logic [2:0] c2_age_reg;  // cycles since that edge, saturating
    // the age gives the design slack for its own edge detector
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            frz_reg     <= 1'b0;
            msk_reg     <= 5'h00;
            c2_prev_reg <= 1'b0;
            c2_pend_reg <= 1'b0;
            c2_age_reg  <= 3'h0;
        end else begin
            c2_prev_reg <= capture_pin_two_in;
            if (wr_in && addr_in == `TFS_OFS_STATUS)
                frz_reg <= wdata_in[`TFS_BIT_FREEZE];
            if (wr_in && addr_in == `TFS_OFS_IRQ_MSK)
                msk_reg <= wdata_in[4:0];
            if (capture_pin_two_in && !c2_prev_reg) begin
                c2_pend_reg <= 1'b1;
                c2_age_reg  <= 3'h0;
            end else begin
                // any capture two low byte access may clear, so stop expecting it
                if ((wr_in || rd_in) && addr_in == `TFS_OFS_CAP2_LO)
                    c2_pend_reg <= 1'b0;
                if (c2_age_reg != 3'h7)
                    c2_age_reg <= c2_age_reg + 3'h1;
            end
        end
    end
    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    sequence s_stat_rd;
        rd_in && addr_in == `TFS_OFS_STATUS;
    endsequence
    sequence s_cap2_old;
        c2_pend_reg && c2_age_reg >= 3'h3;
    endsequence
    a_rdata_idle: assert property (!rd_in |=> rdata_out == 8'h00)
        else $error("read data not zero outside a read");
    a_reset_quiet: assert property ($rose(rst_b_in) |-> !irq_out &&
        !compare_output_pin_one_out && !compare_output_pin_two_out)
        else $error("outputs active right after reset");
    a_status_low_zero: assert property (s_stat_rd |=>
        rdata_out[1:0] == 2'b00) else $error("status low bits not zero");
    a_freeze_readback: assert property (s_stat_rd |=>
        rdata_out[`TFS_BIT_FREEZE] == $past(frz_reg))
        else $error("freeze bit reads back wrong");
    a_freeze_outputs: assert property (frz_reg |->
        !compare_output_pin_one_out && !compare_output_pin_two_out)
        else $error("compare outputs active while frozen");
    a_irq_masked: assert property (msk_reg == 5'h00 |-> !irq_out)
        else $error("interrupt raised with all masked");
    a_unmapped_zero: assert property (rd_in &&
        addr_in > `TFS_OFS_PRESCL |=> rdata_out == 8'h00)
        else $error("unmapped read not zero");
    a_cap2_flag: assert property (s_stat_rd ##0 s_cap2_old |=>
        rdata_out[`TFS_BIT_CAP2]) else $error("capture two flag missing");
endmodule : tfs_timer_monitor

bind tfs_timer tfs_timer_monitor #(.PRESCALE_RESET(PRESCALE_RESET))
    tfs_timer_monitor_i (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .capture_pin_one_in(capture_pin_one_in),
    .capture_pin_two_in(capture_pin_two_in), .rdata_out(rdata_out),
    .compare_output_pin_one_out(compare_output_pin_one_out),
    .compare_output_pin_two_out(compare_output_pin_two_out),
    .irq_out(irq_out));
`default_nettype wire

// *** tb/tfs_timer_bench.sv ***
// self-checking bench of the timer flag and status block
// assumes design and checker compiled first; prescaler reload set to 0
`timescale 1ns/10ps
`default_nettype none
`include "tfs_cfg.svh"

module tfs_timer_bench;
    import tfs_pkg::*;
    typedef struct packed {
        logic       wr;   // 1 write, 0 read
        logic [4:0] addr; // register offset
        logic [7:0] data; // write data or expected read data
    } tfs_row_t;
    logic       clk_in   = 1'b0;  // 250 MHz clock
    logic       rst_b_in = 1'b0;  // reset, active low
    logic [4:0] addr_in  = 5'h00; // register address
    logic [7:0] wdata_in = 8'h00; // write data
    logic       wr_in    = 1'b0;  // write strobe
    logic       rd_in    = 1'b0;  // read strobe
    logic [1:0] cap_in   = 2'b00; // capture pins, one above two
    logic [7:0] rdata_out;        // read data
    logic       out1;             // compare output one
    logic       out2;             // compare output two
    logic       irq_out;          // interrupt
    logic [7:0] got;              // last read data
    logic [7:0] cnt0;             // frozen counter low byte
    int         err_total = 0;
    int         cmp_count = 0;
    tfs_row_t   rows [12];

    always #2 clk_in = ~clk_in;

    // reload 0: one count per cycle keeps the wrap test short
    tfs_timer #(.PRESCALE_RESET(8'h00)) tfs_timer_i (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .capture_pin_one_in(cap_in[1]), .capture_pin_two_in(cap_in[0]),
        .rdata_out(rdata_out), .compare_output_pin_one_out(out1),
        .compare_output_pin_two_out(out2), .irq_out(irq_out));

    task automatic check(input string nm, input logic [7:0] e,
                         input logic [7:0] s);
        cmp_count++;
        if (e !== s) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask : check

    // one strobe cycle; read data taken in the cycle after it
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [7:0] d);
        @(posedge clk_in);
        wr_in    <= w;
        rd_in    <= !w;
        addr_in  <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
        rd_in <= 1'b0;
        #1 got = rdata_out;
    endtask : bus

    task automatic rdc(input string nm, input logic [4:0] a,
                       input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        check(nm, e, got);
    endtask : rdc

    task automatic pulse(input logic [1:0] p);
        @(posedge clk_in);
        cap_in <= p;
        repeat (3) @(posedge clk_in);
        cap_in <= 2'b00;
        repeat (3) @(posedge clk_in);
        #1;
    endtask : pulse

    task automatic give_verdict();
        if (err_total == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : give_verdict

    // watchdog: the wrap test needs about 66000 cycles
    initial begin
        repeat (90000) @(posedge clk_in);
        err_total++;
        give_verdict();
    end

    initial begin
        rows = '{'{1'b0, 5'h0a, 8'hff}, '{1'b0, 5'h0d, 8'hff},
                 '{1'b0, 5'h06, 8'h00}, '{1'b0, 5'h09, 8'h00},
                 '{1'b0, 5'h0f, 8'h00}, '{1'b0, 5'h10, 8'h00},
                 '{1'b1, 5'h1f, 8'haa}, '{1'b0, 5'h1f, 8'h00},
                 '{1'b1, 5'h02, 8'h55}, '{1'b0, 5'h02, 8'h00},
                 '{1'b0, 5'h00, 8'h04}, '{1'b0, 5'h01, 8'h00}};
        repeat (12) @(posedge clk_in);
        rst_b_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        rdc("status reset", `TFS_OFS_STATUS, 8'h00);
        bus(1'b1, `TFS_OFS_STATUS, 8'h04);
        bus(1'b0, `TFS_OFS_CNT_LO, 8'h00);
        cnt0 = got;
        repeat (5) @(posedge clk_in);
        rdc("frozen count", `TFS_OFS_CNT_LO, cnt0);
        // register table while frozen
        foreach (rows[i]) begin
            bus(rows[i].wr, rows[i].addr, rows[i].data);
            if (!rows[i].wr) check("table read", rows[i].data, got);
        end
        // compare one lands 32 counts after release of the freeze
        bus(1'b1, `TFS_OFS_CMP1_HI, 8'h00);
        bus(1'b1, `TFS_OFS_CMP1_LO, cnt0 + 8'h20);
        bus(1'b1, `TFS_OFS_STATUS, 8'h00);
        repeat (48) @(posedge clk_in);
        check("out one", 8'h01, {7'h00, out1});
        rdc("match one", `TFS_OFS_STATUS, 8'h40);
        bus(1'b0, `TFS_OFS_CMP2_LO, 8'h00);
        rdc("wrong low", `TFS_OFS_STATUS, 8'h40);
        bus(1'b1, `TFS_OFS_CMP1_LO, cnt0 + 8'h20);
        rdc("one cleared", `TFS_OFS_STATUS, 8'h00);
        // one full wrap: rollover, compare two at ffff, compare one again
        repeat (65600) @(posedge clk_in);
        rdc("wrap", `TFS_OFS_STATUS, 8'h68);
        check("outputs", 8'h01, {6'h00, out1, out2});
        bus(1'b0, `TFS_OFS_ALT_LO, 8'h00);
        rdc("alt low", `TFS_OFS_STATUS, 8'h68);
        bus(1'b0, `TFS_OFS_CNT_LO, 8'h00);
        rdc("main low", `TFS_OFS_STATUS, 8'h48);
        bus(1'b0, `TFS_OFS_CMP2_LO, 8'h00);
        rdc("two low", `TFS_OFS_STATUS, 8'h40);
        bus(1'b0, `TFS_OFS_CMP1_LO, 8'h00);
        rdc("one low", `TFS_OFS_STATUS, 8'h00);
        // captures with interrupt set, mask and clear
        bus(1'b1, `TFS_OFS_IRQ_ST, 8'h1f);
        rdc("irq clear", `TFS_OFS_IRQ_ST, 8'h00);
        bus(1'b1, `TFS_OFS_IRQ_MSK, 8'h02);
        pulse(2'b01);
        check("irq cap two", 8'h01, {7'h00, irq_out});
        rdc("cap two", `TFS_OFS_STATUS, 8'h10);
        bus(1'b1, `TFS_OFS_IRQ_MSK, 8'h00);
        pulse(2'b10);
        check("irq masked", 8'h00, {7'h00, irq_out});
        bus(1'b1, `TFS_OFS_IRQ_MSK, 8'h10);
        check("irq unmasked", 8'h01, {7'h00, irq_out});
        bus(1'b1, `TFS_OFS_IRQ_ST, 8'h10);
        check("irq cleared", 8'h00, {7'h00, irq_out});
        rdc("both caps", `TFS_OFS_STATUS, 8'h90);
        bus(1'b0, `TFS_OFS_CAP1_LO, 8'h00);
        rdc("cap one low", `TFS_OFS_STATUS, 8'h10);
        bus(1'b1, `TFS_OFS_CAP2_LO, 8'h00);
        rdc("cap two low", `TFS_OFS_STATUS, 8'h00);
        give_verdict();
    end
endmodule : tfs_timer_bench
`default_nettype wire
